// file: design/oecc_regs.vh
// register map, field positions and reset values of the oscillator enable control block
// assumes a classic wishbone slave with 32-bit data and byte-lane selects
//
// Contract
// - The control register takes byte, half-word and word accesses and answers each without extra wait states.
// - Bits 30 to 26 of the control register are reserved, read as zero and are left at zero by software.
// - The loop stable flag at bit 24+1 is read-only, set by hardware when the loop is ready and resets to 0.
// - Software sets and clears the loop enable at bit 24, 1 meaning on, resetting to 0.
// - Entry to Standby or Deepsleep clears the loop enable and the external oscillator enable by hardware.
// - While the loop drives the system clock a software clear of the loop enable is ignored.
// - Bit 19 switches the clock failure detector on or off and resets to 0.
// - Bit 18 selects bypass of the external crystal when 1 and resets to 0.
// - A write to the bypass select only takes effect while the external oscillator is disabled.
// - The external stable flag at bit 17 is read-only, set by hardware when the oscillator is stable and resets to 0.
// - Software turns the external oscillator on or off through bit 16, 1 meaning on, resetting to 0.
// - While the external oscillator drives the system clock a software clear of its enable is ignored; the code does so only when it is selected directly.
// - The system clock only switches to a requested source once that source reports stable.
// - An external oscillator failure moves the system clock to the internal oscillator and stops detector, external oscillator and, if used, the loop.
// - A source becoming stable raises an interrupt request when its interrupt is enabled.
`ifndef OECC_REGS_VH
`define OECC_REGS_VH

// byte offsets
`define OECC_CTRL_OFS        8'h00
`define OECC_INT_STS_OFS     8'h04
`define OECC_INT_CLR_OFS     8'h08
`define OECC_INT_EN_OFS      8'h0C
`define OECC_LOOP_CFG_OFS    8'h10
`define OECC_SYS_SEL_OFS     8'h14

// control register fields
`define OECC_LOOP_STABLE_BIT 25
`define OECC_LOOP_EN_BIT     24
`define OECC_FDET_EN_BIT     19
`define OECC_BYPASS_BIT      18
`define OECC_EXT_STABLE_BIT  17
`define OECC_EXT_EN_BIT      16
`define OECC_RESD_HI         30
`define OECC_RESD_LO         26

// loop configuration fields
`define OECC_LOOP_SRC_BIT    0
`define OECC_LOOP_MULT_LO    1
`define OECC_LOOP_MULT_HI    6

// system clock select fields
`define OECC_REQ_LO          0
`define OECC_REQ_HI          1
`define OECC_CUR_LO          2
`define OECC_CUR_HI          3

// source codes
`define OECC_SRC_INT         2'h0
`define OECC_SRC_EXT         2'h1
`define OECC_SRC_LOOP        2'h2

// interrupt bits
`define OECC_IRQ_EXT_BIT     0
`define OECC_IRQ_LOOP_BIT    1
`define OECC_IRQ_FAIL_BIT    2
`define OECC_IRQ_W           3

// reset values
`define OECC_CTRL_RST        32'h0000_0000
`define OECC_LOOP_CFG_RST    7'h00
`define OECC_IRQ_RST         3'h0

`endif

// file: design/oecc_sync.v
// two-flop synchroniser for a bundle of independent level inputs
// assumes each bit is a slow level from another domain; no bus coherence across bits
`timescale 1ns/1ps
`default_nettype none

module oecc_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] d_i,
    output reg  [WIDTH-1:0] q_o
);

    reg [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= {WIDTH{1'b0}};
            q_o    <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule // oecc_sync

`default_nettype wire

// file: design/oecc_stable.v
// stable flag of one clock source, qualified by its enable, with a rise pulse
// assumes ready_i is already synchronised to clk_i
`timescale 1ns/1ps
`default_nettype none

module oecc_stable (
    input  wire clk_i,
    input  wire rst_i,
    input  wire en_i,
    input  wire ready_i,
    output reg  stable_o,
    output reg  rise_o
);

    wire stable_nxt;

    // enable gates the flag so a stopped source never reads ready
    assign stable_nxt = en_i & ready_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            stable_o <= 1'b0;
            rise_o   <= 1'b0;
        end else begin
            stable_o <= stable_nxt;
            rise_o   <= stable_nxt & ~stable_o;
        end
    end

endmodule // oecc_stable

`default_nettype wire

// file: design/oecc_top.v
// oscillator enable control: control register, loop configuration, system clock
// selection, failure handling and stable-event interrupts behind a wishbone slave
// assumes analogue ready and failure indications arrive asynchronously on pins and
// low-power entry strobes come from logic on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "oecc_regs.vh"

module oecc_top (
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // analogue side
    input  wire        ext_ready_i,
    input  wire        loop_ready_i,
    input  wire        ext_fail_i,
    input  wire        standby_entry_i,
    input  wire        deepsleep_entry_i,
    output reg         ext_osc_en_o,
    output reg         ext_bypass_o,
    output reg         loop_en_o,
    output reg         fail_det_en_o,
    output reg         loop_src_o,
    output reg  [5:0]  loop_mult_o,
    output reg  [1:0]  sys_clk_sel_o,
    output reg         irq_o
);

    // byte-lane mask from the select lines
    function [31:0] lane_mask;
        input [3:0] sel;
        begin
            lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        end
    endfunction

    // a source code is valid only for the three defined sources
    function src_valid;
        input [1:0] code;
        begin
            src_valid = (code == `OECC_SRC_INT) || (code == `OECC_SRC_EXT) ||
                        (code == `OECC_SRC_LOOP);
        end
    endfunction

    // register state
    reg        ext_en_r;
    reg        ext_en_nxt;
    reg        bypass_r;
    reg        bypass_nxt;
    reg        loop_en_r;
    reg        loop_en_nxt;
    reg        fdet_en_r;
    reg        fdet_en_nxt;
    reg        loop_src_r;
    reg        loop_src_nxt;
    reg  [5:0] loop_mult_r;
    reg  [5:0] loop_mult_nxt;
    reg  [1:0] req_r;
    reg  [1:0] req_nxt;
    reg  [1:0] cur_r;
    reg  [1:0] cur_nxt;
    reg  [`OECC_IRQ_W-1:0] sts_r;
    reg  [`OECC_IRQ_W-1:0] sts_nxt;
    reg  [`OECC_IRQ_W-1:0] ien_r;
    reg  [`OECC_IRQ_W-1:0] ien_nxt;
    reg  [31:0] rd_nxt;

    // reset image of the control register, split into its fields below
    wire [31:0] ctrl_rst;

    assign ctrl_rst = `OECC_CTRL_RST;

    // pins from the analogue domain
    wire [2:0] pin_sync;
    wire       ext_ready_s;
    wire       loop_ready_s;
    wire       ext_fail_s;

    oecc_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({ext_fail_i, loop_ready_i, ext_ready_i}),
        .q_o   (pin_sync)
    );

    assign ext_ready_s  = pin_sync[0];
    assign loop_ready_s = pin_sync[1];
    assign ext_fail_s   = pin_sync[2];

    // stable flags: index 0 external oscillator, index 1 loop
    wire [1:0] src_en;
    wire [1:0] src_ready;
    wire [1:0] stable;
    wire [1:0] stable_rise;

    // next-state enables, so a flag drops on the same edge as its enable
    assign src_en    = {loop_en_nxt, ext_en_nxt};
    assign src_ready = {loop_ready_s, ext_ready_s};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_stable
            oecc_stable u_stable (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .en_i     (src_en[g]),
                .ready_i  (src_ready[g]),
                .stable_o (stable[g]),
                .rise_o   (stable_rise[g])
            );
        end
    endgenerate

    wire ext_stable;
    wire loop_stable;

    assign ext_stable  = stable[0];
    assign loop_stable = stable[1];

    // bus decode; every access is answered in the cycle after the strobe
    wire bus_req;
    wire bus_wr;
    wire [31:0] wmask;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = bus_req & wb_we_i;
    assign wmask   = lane_mask(wb_sel_i);

    wire wr_ctrl;
    wire wr_clr;
    wire wr_ien;
    wire wr_cfg;
    wire wr_sel;

    assign wr_ctrl = bus_wr && (wb_adr_i == `OECC_CTRL_OFS);
    assign wr_clr  = bus_wr && (wb_adr_i == `OECC_INT_CLR_OFS);
    assign wr_ien  = bus_wr && (wb_adr_i == `OECC_INT_EN_OFS);
    assign wr_cfg  = bus_wr && (wb_adr_i == `OECC_LOOP_CFG_OFS);
    assign wr_sel  = bus_wr && (wb_adr_i == `OECC_SYS_SEL_OFS);

    // current register images
    wire [31:0] ctrl_img;
    wire [31:0] cfg_img;
    wire [31:0] sel_img;

    // reserved bits always read zero
    assign ctrl_img = {1'b0, 5'h00, loop_stable, loop_en_r, 4'h0, fdet_en_r,
                       bypass_r, ext_stable, ext_en_r, 16'h0000};
    assign cfg_img  = {25'h0000000, loop_mult_r, loop_src_r};
    assign sel_img  = {28'h0000000, cur_r, req_r};

    // merged write data: unselected lanes keep their value
    wire [31:0] ctrl_wv;
    wire [31:0] cfg_wv;
    wire [31:0] sel_wv;

    assign ctrl_wv = (ctrl_img & ~wmask) | (wb_dat_i & wmask);
    assign cfg_wv  = (cfg_img & ~wmask) | (wb_dat_i & wmask);
    assign sel_wv  = (sel_img & ~wmask) | (wb_dat_i & wmask);

    // hardware events
    wire low_power;
    wire ext_in_use;
    wire fail_evt;

    assign low_power  = standby_entry_i | deepsleep_entry_i;
    // external oscillator feeds the system clock directly or through the loop
    assign ext_in_use = (cur_r == `OECC_SRC_EXT) ||
                        ((cur_r == `OECC_SRC_LOOP) && loop_src_r);
    assign fail_evt   = ext_fail_s & fdet_en_r & ext_in_use;

    // control register update; hardware clears outrank software
    always @* begin
        ext_en_nxt  = ext_en_r;
        bypass_nxt  = bypass_r;
        loop_en_nxt = loop_en_r;
        fdet_en_nxt = fdet_en_r;
        if (wr_ctrl) begin
            loop_en_nxt = ctrl_wv[`OECC_LOOP_EN_BIT];
            if (cur_r == `OECC_SRC_LOOP) begin
                loop_en_nxt = 1'b1;
            end
            ext_en_nxt = ctrl_wv[`OECC_EXT_EN_BIT];
            if (cur_r == `OECC_SRC_EXT) begin
                ext_en_nxt = 1'b1;
            end
            fdet_en_nxt = ctrl_wv[`OECC_FDET_EN_BIT];
            if (!ext_en_r) begin
                bypass_nxt = ctrl_wv[`OECC_BYPASS_BIT];
            end
        end
        if (fail_evt) begin
            ext_en_nxt  = 1'b0;
            fdet_en_nxt = 1'b0;
            if (cur_r == `OECC_SRC_LOOP) begin
                loop_en_nxt = 1'b0;
            end
        end
        if (low_power) begin
            ext_en_nxt  = 1'b0;
            loop_en_nxt = 1'b0;
        end
    end

    // loop settings are frozen while the loop runs
    always @* begin
        loop_src_nxt  = loop_src_r;
        loop_mult_nxt = loop_mult_r;
        if (wr_cfg && !loop_en_r) begin
            loop_src_nxt  = cfg_wv[`OECC_LOOP_SRC_BIT];
            loop_mult_nxt = cfg_wv[`OECC_LOOP_MULT_HI:`OECC_LOOP_MULT_LO];
        end
    end

    // system clock selection
    always @* begin
        req_nxt = req_r;
        cur_nxt = cur_r;
        if (wr_sel && src_valid(sel_wv[`OECC_REQ_HI:`OECC_REQ_LO])) begin
            req_nxt = sel_wv[`OECC_REQ_HI:`OECC_REQ_LO];
        end
        case (req_r)
            `OECC_SRC_INT: begin
                cur_nxt = `OECC_SRC_INT;
            end
            `OECC_SRC_EXT: begin
                // never land on a source whose enable drops on this edge
                if (ext_stable && ext_en_nxt) begin
                    cur_nxt = `OECC_SRC_EXT;
                end
            end
            `OECC_SRC_LOOP: begin
                if (loop_stable && loop_en_nxt) begin
                    cur_nxt = `OECC_SRC_LOOP;
                end
            end
            default: begin
                cur_nxt = cur_r;
            end
        endcase
        // fall back to the internal oscillator, which is always running
        if (fail_evt || low_power) begin
            req_nxt = `OECC_SRC_INT;
            cur_nxt = `OECC_SRC_INT;
        end
    end

    // interrupt status: a new event wins over a clear in the same cycle
    wire [`OECC_IRQ_W-1:0] evt;

    assign evt = {fail_evt, stable_rise[1], stable_rise[0]};

    always @* begin
        sts_nxt = sts_r;
        ien_nxt = ien_r;
        if (wr_clr) begin
            sts_nxt = sts_r & ~wb_dat_i[`OECC_IRQ_W-1:0];
        end
        sts_nxt = sts_nxt | evt;
        if (wr_ien && wb_sel_i[0]) begin
            ien_nxt = wb_dat_i[`OECC_IRQ_W-1:0];
        end
    end

    // read mux; unmapped and write-only offsets read zero
    always @* begin
        case (wb_adr_i)
            `OECC_CTRL_OFS:     rd_nxt = ctrl_img;
            `OECC_INT_STS_OFS:  rd_nxt = {29'h00000000, sts_r};
            `OECC_INT_EN_OFS:   rd_nxt = {29'h00000000, ien_r};
            `OECC_LOOP_CFG_OFS: rd_nxt = cfg_img;
            `OECC_SYS_SEL_OFS:  rd_nxt = sel_img;
            default:            rd_nxt = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_en_r    <= ctrl_rst[`OECC_EXT_EN_BIT];
            bypass_r    <= ctrl_rst[`OECC_BYPASS_BIT];
            loop_en_r   <= ctrl_rst[`OECC_LOOP_EN_BIT];
            fdet_en_r   <= ctrl_rst[`OECC_FDET_EN_BIT];
            loop_src_r  <= 1'b0;
            loop_mult_r <= 6'h00;
            req_r       <= `OECC_SRC_INT;
            cur_r       <= `OECC_SRC_INT;
            sts_r       <= `OECC_IRQ_RST;
            ien_r       <= `OECC_IRQ_RST;
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0000_0000;
        end else begin
            ext_en_r    <= ext_en_nxt;
            bypass_r    <= bypass_nxt;
            loop_en_r   <= loop_en_nxt;
            fdet_en_r   <= fdet_en_nxt;
            loop_src_r  <= loop_src_nxt;
            loop_mult_r <= loop_mult_nxt;
            req_r       <= req_nxt;
            cur_r       <= cur_nxt;
            sts_r       <= sts_nxt;
            ien_r       <= ien_nxt;
            wb_ack_o    <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // outputs load the same next-state values as the registers, so each pin
    // equals its field with no extra flop of lag
    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_osc_en_o  <= 1'b0;
            ext_bypass_o  <= 1'b0;
            loop_en_o     <= 1'b0;
            fail_det_en_o <= 1'b0;
            loop_src_o    <= 1'b0;
            loop_mult_o   <= 6'h00;
            sys_clk_sel_o <= `OECC_SRC_INT;
            irq_o         <= 1'b0;
        end else begin
            ext_osc_en_o  <= ext_en_nxt;
            ext_bypass_o  <= bypass_nxt;
            loop_en_o     <= loop_en_nxt;
            fail_det_en_o <= fdet_en_nxt;
            loop_src_o    <= loop_src_nxt;
            loop_mult_o   <= loop_mult_nxt;
            sys_clk_sel_o <= cur_nxt;
            irq_o         <= |(sts_nxt & ien_nxt);
        end
    end

endmodule // oecc_top

`default_nettype wire

// file: dv/oecc_top_asserts.sv
// port checker for the oscillator enable control block
// assumes a bind into oecc_top, one clock and a synchronous reset
`timescale 1ns/1ps
`default_nettype none

module oecc_top_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        ext_fail_i,
    input wire logic        standby_entry_i,
    input wire logic        deepsleep_entry_i,
    input wire logic        ext_osc_en_o,
    input wire logic        ext_bypass_o,
    input wire logic        loop_en_o,
    input wire logic        fail_det_en_o,
    input wire logic [1:0]  sys_clk_sel_o
);
    wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic wr0 = req & wb_we_i & (wb_adr_i == 8'h00);
    // low-power and failure override the clear locks
    wire logic lp = standby_entry_i | deepsleep_entry_i;
    wire logic calm = ~lp & ~fail_det_en_o;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_next: assert property (req |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_resd_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00
        |-> wb_dat_o[30:26] == 5'h00) else $error("reserved bits not zero");
    a_ext_set: assert property (wr0 && wb_sel_i[2] && wb_dat_i[16] && calm
        |=> ext_osc_en_o) else $error("oscillator enable not set");
    a_lowpwr_clr: assert property (lp
        |=> !ext_osc_en_o && !loop_en_o) else $error("enables kept in low power");
    a_loop_lock: assert property (wr0 && wb_sel_i[3] && !wb_dat_i[24] && calm
        && sys_clk_sel_o == 2'h2 |=> loop_en_o) else $error("loop enable cleared in use");
    a_ext_lock: assert property (wr0 && wb_sel_i[2] && !wb_dat_i[16] && calm
        && sys_clk_sel_o == 2'h1 |=> ext_osc_en_o) else $error("ext enable cleared in use");
    a_byp_lock: assert property (wr0 && wb_sel_i[2] && ext_osc_en_o
        |=> $stable(ext_bypass_o)) else $error("bypass changed while running");
    a_sel_ready: assert property (sys_clk_sel_o == 2'h1 && $past(sys_clk_sel_o) != 2'h1
        |-> ext_osc_en_o) else $error("switched to stopped source");
    a_fail_move: assert property (fail_det_en_o && sys_clk_sel_o == 2'h1 && ext_fail_i
        ##1 ext_fail_i[*2]
        |-> ##[0:4] (sys_clk_sel_o == 2'h0 && !ext_osc_en_o && !fail_det_en_o))
        else $error("failure not handled");
endmodule // oecc_top_chk

bind oecc_top oecc_top_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_fail_i, .standby_entry_i,
    .deepsleep_entry_i, .ext_osc_en_o, .ext_bypass_o, .loop_en_o, .fail_det_en_o,
    .sys_clk_sel_o);

`default_nettype wire

// file: dv/oecc_osc_model.sv
// behavioural oscillators and multiplier loop behind the control block
// assumes enables come from the block; ready follows after a start-up count
`timescale 1ns/1ps
`default_nettype none

module oecc_osc_model #(
    parameter int START = 6
) (
    input  wire logic clk_i,
    input  wire logic ext_en_i,
    input  wire logic loop_en_i,
    input  wire logic fail_cmd_i,
    output logic      ext_ready_o,
    output logic      loop_ready_o,
    output logic      ext_fail_o
);
    int ext_cnt = 0;
    int loop_cnt = 0;

    always @(posedge clk_i) begin
        ext_cnt <= ext_en_i ? ext_cnt + 1 : 0;
        loop_cnt <= loop_en_i ? loop_cnt + 1 : 0;
    end
    // a stopped source drops ready at once, never reports stale
    assign ext_ready_o = ext_en_i && ext_cnt >= START;
    assign loop_ready_o = loop_en_i && loop_cnt >= START;
    assign ext_fail_o = fail_cmd_i & ext_en_i;
endmodule // oecc_osc_model

`default_nettype wire

// file: dv/test_oscillator_enable_control.sv
// self-checking bench for the oscillator enable control block
// assumes oecc_top, the oscillator model and the bound checker
`timescale 1ns/1ps
`default_nettype none

module test_oscillator_enable_control;
    logic        clk_i, rst_i, cyc, stb, we, stby, dslp, fcmd;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat;
    logic        ack, ext_en, byp, loop_en, fdet, lsrc, irq, erdy, lrdy, fail;
    logic [5:0]  lmult;
    logic [1:0]  sysc;
    int          failures = 0;
    int          cmp_count = 0;

    oecc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_ready_i(erdy), .loop_ready_i(lrdy), .ext_fail_i(fail),
        .standby_entry_i(stby), .deepsleep_entry_i(dslp), .ext_osc_en_o(ext_en),
        .ext_bypass_o(byp), .loop_en_o(loop_en), .fail_det_en_o(fdet),
        .loop_src_o(lsrc), .loop_mult_o(lmult), .sys_clk_sel_o(sysc), .irq_o(irq));
    oecc_osc_model osc_u (.clk_i(clk_i), .ext_en_i(ext_en), .loop_en_i(loop_en),
        .fail_cmd_i(fcmd), .ext_ready_o(erdy), .loop_ready_o(lrdy), .ext_fail_o(fail));

    initial begin
        clk_i = 1'h0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // one classic cycle; returns after ack plus one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (n >= 20) begin
            failures++;
            end_sim();
        end
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, a, s, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'h0, a, 4'hF, 32'h0, q);
        cmp(q, e);
    endtask

    // bounded poll until the masked field reads v
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] q;
        int n;
        n = 0;
        wb(1'h0, a, 4'hF, 32'h0, q);
        while ((q & m) !== v) begin
            n++;
            if (n > 30) begin
                failures++;
                end_sim();
            end
            wb(1'h0, a, 4'hF, 32'h0, q);
        end
    endtask

    task automatic t_reset();
        rd(8'h00, 32'h0);
        rd(8'h20, 32'h0);
        rd(8'h14, 32'h0);
    endtask

    task automatic t_fields();
        wr(8'h00, 4'h4, 32'h000C_0000);
        rd(8'h00, 32'h000C_0000);
        cmp(32'({fdet, byp}), 32'h3);
        wr(8'h00, 4'h8, 32'h7C00_0000);
        rd(8'h00, 32'h000C_0000);
        wr(8'h00, 4'h4, 32'h0);
        rd(8'h00, 32'h0);
    endtask

    task automatic t_ext();
        wr(8'h0C, 4'hF, 32'h7);
        wr(8'h00, 4'h4, 32'h0001_0000);
        poll(8'h00, 32'h0002_0000, 32'h0002_0000);
        cmp(32'(irq), 32'h1);
        rd(8'h04, 32'h1);
        wr(8'h0C, 4'hF, 32'h0);
        cmp(32'(irq), 32'h0);
        wr(8'h0C, 4'hF, 32'h7);
        wr(8'h08, 4'hF, 32'h1);
        cmp(32'(irq), 32'h0);
        wr(8'h00, 4'h4, 32'h0005_0000);
        cmp(32'(byp), 32'h0);
        wr(8'h14, 4'hF, 32'h1);
        poll(8'h14, 32'hC, 32'h4);
        cmp(32'(sysc), 32'h1);
        wr(8'h14, 4'hF, 32'h3);
        rd(8'h14, 32'h5);
        wr(8'h00, 4'h4, 32'h0);
        rd(8'h00, 32'h0003_0000);
        wr(8'h14, 4'hF, 32'h0);
        poll(8'h14, 32'hC, 32'h0);
        wr(8'h00, 4'h4, 32'h0);
        poll(8'h00, 32'h0003_0000, 32'h0);
    endtask

    task automatic t_loop();
        wr(8'h10, 4'hF, 32'h0A);
        wr(8'h00, 4'h8, 32'h0100_0000);
        poll(8'h00, 32'h0200_0000, 32'h0200_0000);
        rd(8'h04, 32'h2);
        wr(8'h08, 4'hF, 32'h2);
        wr(8'h10, 4'hF, 32'h04);
        rd(8'h10, 32'h0A);
        cmp(32'({lmult, lsrc}), 32'h0A);
        wr(8'h14, 4'hF, 32'h2);
        poll(8'h14, 32'hC, 32'h8);
        cmp(32'(sysc), 32'h2);
        wr(8'h00, 4'h8, 32'h0);
        rd(8'h00, 32'h0300_0000);
        cmp(32'({loop_en, ext_en}), 32'h2);
    endtask

    task automatic t_lowpwr();
        for (int i = 0; i < 2; i++) begin
            wr(8'h00, 4'hC, 32'h0101_0000);
            stby <= (i == 0);
            dslp <= (i == 1);
            @(posedge clk_i);
            stby <= 1'h0;
            dslp <= 1'h0;
            rd(8'h00, 32'h0);
            rd(8'h14, 32'h0);
            cmp(32'({ext_en, loop_en, sysc}), 32'h0);
        end
    endtask

    task automatic t_fail();
        wr(8'h00, 4'h4, 32'h0009_0000);
        poll(8'h00, 32'h0002_0000, 32'h0002_0000);
        wr(8'h14, 4'hF, 32'h1);
        poll(8'h14, 32'hC, 32'h4);
        fcmd <= 1'h1;
        poll(8'h14, 32'hC, 32'h0);
        fcmd <= 1'h0;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h5);
        cmp(32'({ext_en, fdet, sysc}), 32'h0);
        cmp(32'(irq), 32'h1);
    endtask

    initial begin
        rst_i = 1'h1;
        {cyc, stb, we, stby, dslp, fcmd} = 6'h00;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_reset();
        t_fields();
        t_ext();
        t_loop();
        t_lowpwr();
        t_fail();
        end_sim();
    end
endmodule // test_oscillator_enable_control

`default_nettype wire
